// File: design/osd_character_generator.sv
// How it works
// - cells 14x18 from 512 patterns
// - 7-bit words, even left, odd right
// - character words 00h-23h, next at 40h
// - pattern 0 background, 1 foreground
// - four sizes; 2X doubles both ways
// - smoothing only for 2X, double width
// - attribute bit 4 low enables smoothing
// - bit 5 fringe; colour from status bits
// - no fringe in progressive mode
// - colours coded red msb, blue lsb
// - bit 7 low shows every character blank
// - bit 6 mutes video, shows master colour
// - bit 3 inverts colour outputs
// - ram word: 9-bit code, 3-bit palette
// - byte write merges palette index bits
// - palette bits index colour lookup table
// - palette 0 uses row attribute colours
// - index reg: bit3 msb, upper nibble ones
//
// Our own choice: the AXI4-Lite register port.
module osd_character_generator
    import osd_pkg::*;
#(
    parameter int unsigned NUM_COLS = 24,
    parameter int unsigned NUM_ROWS = 10,
    parameter int unsigned PIX_DIV = PIX_DIV_DEF
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic line_start,
    input wire logic [3:0] row_index,
    input wire logic [5:0] row_line,
    output logic [14:0] rom_addr,
    input wire logic [6:0] rom_data,
    output logic [2:0] osd_rgb,
    output logic osd_blank,
    output logic video_mute
);

    localparam int unsigned NUM_CELLS = NUM_ROWS * NUM_COLS;
    localparam int unsigned COL_W = $clog2(NUM_COLS);

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_got_q, w_got_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] awaddr_q, rd_addr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic [31:0] rdata_q, rd_mux;
    logic rd_known;
    logic [7:0] display_attribute_ctrl_q;
    logic [3:0] fringe_q;
    logic [3:0] pidx_q;
    logic [2:0] mode_q;
    logic [5:0] row_attribute_word_q;
    logic [5:0] palette_q [7];
    logic [11:0] video_refresh_ram_q [NUM_CELLS];
    logic [7:0] video_refresh_ram_addr_q;
    logic [2:0] osd_rgb_q;
    logic osd_blank_q, video_mute_q;

    wire pix_en, busy, pix_valid, pix_fg, pix_edge;
    wire [2:0] pix_pal;
    wire [COL_W-1:0] col;

    // bus handshakes and write decode
    wire aw_hs = awvalid && awready_q;
    wire w_hs = wvalid && wready_q;
    wire b_hs = bvalid_q && bready;
    wire ar_hs = arvalid && arready_q;
    wire r_hs = rvalid_q && rready;
    wire do_write = aw_got_q && w_got_q && !bvalid_q;
    wire wr_b0 = do_write && wstrb_q[0];
    wire [2:0] wr_slot = awaddr_q[4:2];
    wire hit_pal = ((awaddr_q & ~ADDR_PAL_MASK) == ADDR_PALETTE) && (wr_slot != PAL_SLOT_NONE);
    wire wr_disp = wr_b0 && (awaddr_q == ADDR_DISPLAY_ATTRIBUTE_CTRL);
    wire wr_fringe = wr_b0 && (awaddr_q == ADDR_INT_STATUS);
    wire wr_pidx = wr_b0 && (awaddr_q == ADDR_PAL_INDEX);
    wire wr_mode = wr_b0 && (awaddr_q == ADDR_MODE);
    wire wr_row = wr_b0 && (awaddr_q == ADDR_ROW_ATTRIBUTE_WORD);
    wire wr_pal = wr_b0 && hit_pal;
    wire wr_video_refresh_ram = do_write && (&wstrb_q) && (awaddr_q == ADDR_VIDEO_REFRESH_RAM)
        && (32'(wdata_q[15:8]) < NUM_CELLS);
    wire wr_known = (awaddr_q == ADDR_DISPLAY_ATTRIBUTE_CTRL) || (awaddr_q == ADDR_INT_STATUS)
        || (awaddr_q == ADDR_PAL_INDEX) || (awaddr_q == ADDR_MODE)
        || (awaddr_q == ADDR_ROW_ATTRIBUTE_WORD) || (awaddr_q == ADDR_VIDEO_REFRESH_RAM)
        || (awaddr_q == ADDR_STATUS) || hit_pal;
    wire [11:0] video_refresh_ram_new = {pidx_q[PI_MSB], pidx_q[2:0], wdata_q[7:0]};
    wire [11:0] video_refresh_ram_last = video_refresh_ram_q[video_refresh_ram_addr_q];
    wire [2:0] rd_slot = araddr[4:2];
    wire rd_pal = ((araddr & ~ADDR_PAL_MASK) == ADDR_PALETTE) && (rd_slot != PAL_SLOT_NONE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'b00;
        end
        else
        begin
            if (aw_hs)
            begin
                awaddr_q <= awaddr;
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (w_hs)
            begin
                wdata_q <= wdata[15:0];
                wstrb_q <= wstrb[1:0];
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_hs)
            begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            display_attribute_ctrl_q <= DISPLAY_ATTRIBUTE_CTRL_RST;
            fringe_q <= FRINGE_RST;
            pidx_q <= PAL_INDEX_RST;
            mode_q <= MODE_RST;
            row_attribute_word_q <= COLOUR_PAIR_RST;
            video_refresh_ram_addr_q <= 8'h00;
        end
        else
        begin
            if (wr_disp)
                display_attribute_ctrl_q <= wdata_q[7:0];
            if (wr_fringe)
                fringe_q <= wdata_q[7:4];
            if (wr_pidx)
                pidx_q <= wdata_q[3:0];
            if (wr_mode)
                mode_q <= wdata_q[2:0];
            if (wr_row)
                row_attribute_word_q <= wdata_q[5:0];
            if (wr_video_refresh_ram)
                video_refresh_ram_addr_q <= wdata_q[15:8];
        end
    end

    for (genvar i = 0; i < 7; i++)
    begin : g_pal
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                palette_q[i] <= COLOUR_PAIR_RST;
            else if (wr_pal && (wr_slot == 3'(i)))
                palette_q[i] <= wdata_q[5:0];
        end
    end

    // whole video ram in flops; a wider screen costs area linearly
    for (genvar i = 0; i < NUM_CELLS; i++)
    begin : g_video_refresh_ram
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                video_refresh_ram_q[i] <= VIDEO_REFRESH_RAM_RST;
            else if (wr_video_refresh_ram && (wdata_q[15:8] == 8'(i)))
                video_refresh_ram_q[i] <= video_refresh_ram_new;
        end
    end

    always_comb
    begin
        rd_known = 1'b1;
        rd_mux = 32'h0000_0000;
        if (araddr == ADDR_DISPLAY_ATTRIBUTE_CTRL)
            rd_mux = 32'(display_attribute_ctrl_q);
        else if (araddr == ADDR_INT_STATUS)
            rd_mux = 32'({fringe_q, 4'h0});
        else if (araddr == ADDR_PAL_INDEX)
            rd_mux = 32'({PAL_INDEX_PAD, pidx_q});
        else if (araddr == ADDR_MODE)
            rd_mux = 32'(mode_q);
        else if (araddr == ADDR_ROW_ATTRIBUTE_WORD)
            rd_mux = 32'(row_attribute_word_q);
        else if (araddr == ADDR_VIDEO_REFRESH_RAM)
            rd_mux = {4'h0, video_refresh_ram_last, 8'h00, video_refresh_ram_addr_q};
        else if (araddr == ADDR_STATUS)
            rd_mux = 32'({busy, 3'h0, 8'(col)});
        else if (rd_pal)
            rd_mux = 32'(palette_q[rd_slot]);
        else
            rd_known = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            rd_addr_q <= 8'h00;
        end
        else if (ar_hs)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
            rd_addr_q <= araddr;
        end
        else if (r_hs)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    osd_pixel_divider #(.DIV(PIX_DIV)) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(pix_en)
    );

    wire char_en = display_attribute_ctrl_q[DA_CHAR_EN];
    wire smooth_en = !display_attribute_ctrl_q[DA_SMOOTH_DIS];
    wire progressive = mode_q[MODE_PROGRESSIVE];
    wire [7:0] cell_idx = 8'(32'(row_index) * NUM_COLS + 32'(col));
    wire [11:0] video_refresh_ram_word = (32'(cell_idx) < NUM_CELLS) ? video_refresh_ram_q[cell_idx] : VIDEO_REFRESH_RAM_RST;

    osd_cell_fetch #(.NUM_COLS(NUM_COLS), .COL_W(COL_W)) u_fetch (
        .aclk(aclk),
        .aresetn(aresetn),
        .pix_en(pix_en),
        .line_start(line_start),
        .row_line(row_line),
        .size(mode_q[1:0]),
        .char_en(char_en),
        .smooth_en(smooth_en),
        .video_refresh_ram_word(video_refresh_ram_word),
        .col(col),
        .rom_addr(rom_addr),
        .rom_data(rom_data),
        .busy(busy),
        .pix_valid(pix_valid),
        .pix_fg(pix_fg),
        .pix_edge(pix_edge),
        .pix_pal(pix_pal)
    );

    // colour selection; codes reach the rgb pins as is, or inverted when bit 3 is set, red in the msb
    wire [5:0] pair = (pix_pal == 3'h0) ? row_attribute_word_q : palette_q[3'(pix_pal - 3'h1)];
    wire [2:0] fg_col = pair[5:3];
    wire [2:0] bg_col = pair[2:0];
    wire [2:0] fringe_col = fringe_q[FR_SRC] ? fringe_q[2:0] : bg_col;
    wire fringe_hit = pix_edge && display_attribute_ctrl_q[DA_FRINGE_EN] && !progressive;
    wire master_en = display_attribute_ctrl_q[DA_MASTER_BG];
    wire pol = display_attribute_ctrl_q[DA_POLARITY];
    wire [2:0] master_col = display_attribute_ctrl_q[2:0];
    wire [2:0] px_col = pix_fg ? fg_col : (fringe_hit ? fringe_col : bg_col);
    wire [2:0] colour_d = pix_valid ? px_col : (master_en ? master_col : 3'h0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osd_rgb_q <= 3'h0;
            osd_blank_q <= 1'b0;
            video_mute_q <= 1'b0;
        end
        else
        begin
            osd_rgb_q <= colour_d ^ {3{pol}};
            osd_blank_q <= pix_valid || master_en;
            video_mute_q <= master_en;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign osd_rgb = osd_rgb_q;
    assign osd_blank = osd_blank_q;
    assign video_mute = video_mute_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_video_refresh_ram_write;
        wr_video_refresh_ram;
    endsequence

    sequence s_master_gap;
        master_en && !pix_valid;
    endsequence

    AST_VIDEO_REFRESH_RAM_COMPOSE: assert property (s_video_refresh_ram_write |=>
        video_refresh_ram_last == {$past(pidx_q[PI_MSB]), $past(pidx_q[2:0]), $past(wdata_q[7:0])})
        else $error("video ram word not merged with palette index");

    AST_PIDX_PAD: assert property ($rose(rvalid_q) && rd_addr_q == ADDR_PAL_INDEX
        |-> rdata_q[7:4] == PAL_INDEX_PAD && rdata_q[3:0] == $past(pidx_q))
        else $error("palette index readback wrong");

    AST_MASTER_BG: assert property (s_master_gap |=>
        video_mute_q && osd_blank_q && osd_rgb_q == ($past(master_col) ^ {3{$past(pol)}}))
        else $error("master background colour not shown");

    AST_POLARITY: assert property ($rose(pol) && $stable(colour_d)
        |=> osd_rgb_q == ~$past(osd_rgb_q))
        else $error("polarity change did not invert outputs");

    AST_NO_FRINGE_PROG: assert property (progressive && pix_valid && !pix_fg
        |=> osd_rgb_q == ($past(bg_col) ^ {3{$past(pol)}}))
        else $error("fringe active in progressive mode");

    AST_FRINGE_COLOUR: assert property (pix_valid && !pix_fg && fringe_hit
        && fringe_q[FR_SRC] |=> osd_rgb_q == ($past(fringe_q[2:0]) ^ {3{$past(pol)}}))
        else $error("fringe colour wrong");

    AST_ROW_ATTRIBUTE_WORD: assert property (pix_valid && pix_fg && pix_pal == 3'h0
        |=> osd_rgb_q == ($past(row_attribute_word_q[5:3]) ^ {3{$past(pol)}}))
        else $error("palette 0 did not use row attribute");

    AST_CHAR_BLANK: assert property (pix_en && !char_en |=> !pix_fg)
        else $error("character shown while display disabled");

    AST_ROM_RANGE: assert property (rom_addr[5:0] <= CHAR_LAST_WORD)
        else $error("pattern address beyond character area");

    AST_ROM_PAIR: assert property ($changed(rom_addr) && !rom_addr[0]
        |=> rom_addr == $past(rom_addr) + 15'h0001)
        else $error("right half word not fetched after left");

endmodule

// File: design/osd_pkg.sv
package osd_pkg;

    // register byte addresses; printed offsets are indices, byte address is four times
    localparam int unsigned IDX_DISPLAY_ATTRIBUTE_CTRL = 3;
    localparam int unsigned IDX_INT_STATUS = 7;
    localparam int unsigned IDX_PAL_INDEX = 9;
    localparam logic [7:0] ADDR_DISPLAY_ATTRIBUTE_CTRL = 8'(IDX_DISPLAY_ATTRIBUTE_CTRL * 4);
    localparam logic [7:0] ADDR_INT_STATUS = 8'(IDX_INT_STATUS * 4);
    localparam logic [7:0] ADDR_PAL_INDEX = 8'(IDX_PAL_INDEX * 4);
    localparam logic [7:0] ADDR_MODE = 8'h40;
    localparam logic [7:0] ADDR_VIDEO_REFRESH_RAM = 8'h44;
    localparam logic [7:0] ADDR_ROW_ATTRIBUTE_WORD = 8'h48;
    localparam logic [7:0] ADDR_STATUS = 8'h4C;
    localparam logic [7:0] ADDR_PALETTE = 8'h80;
    localparam logic [7:0] ADDR_PAL_MASK = 8'h1C;
    localparam logic [2:0] PAL_SLOT_NONE = 3'h7;

    // display attribute fields
    localparam int unsigned DA_CHAR_EN = 7;
    localparam int unsigned DA_MASTER_BG = 6;
    localparam int unsigned DA_FRINGE_EN = 5;
    localparam int unsigned DA_SMOOTH_DIS = 4;
    localparam int unsigned DA_POLARITY = 3;
    localparam logic [7:0] DISPLAY_ATTRIBUTE_CTRL_RST = 8'h00;

    // fringe fields of the interrupt status register, held as its bits 7..4
    localparam int unsigned FR_SRC = 3;
    localparam logic [3:0] FRINGE_RST = 4'h0;

    // palette index register: bit 3 code msb, bits 2..0 palette select, upper nibble reads ones
    localparam int unsigned PI_MSB = 3;
    localparam logic [3:0] PAL_INDEX_RST = 4'h0;
    localparam logic [3:0] PAL_INDEX_PAD = 4'hF;

    // mode register fields
    localparam int unsigned MODE_PROGRESSIVE = 2;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [5:0] COLOUR_PAIR_RST = 6'h00;

    // video refresh ram word: {char_code_msb, palette_select_bits, char_code_low_byte}
    localparam int unsigned WORD_MSB = 11;
    localparam logic [11:0] VIDEO_REFRESH_RAM_RST = 12'h000;

    // character cell geometry
    localparam int unsigned CELL_W = 14;
    localparam int unsigned HALF_W = 7;
    localparam logic [3:0] LAST_PIX = 4'(CELL_W - 1);
    localparam logic [4:0] LAST_ROW = 5'd17;
    localparam logic [5:0] CHAR_LAST_WORD = 6'h23;

    // character sizes
    localparam logic [1:0] SIZE_NORMAL = 2'b00;
    localparam logic [1:0] SIZE_2X = 2'b01;
    localparam logic [1:0] SIZE_WIDE = 2'b10;
    localparam logic [1:0] SIZE_TALL = 2'b11;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam int unsigned PIX_DIV_DEF = 4;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR_L = 6'b000010,
        ST_ADDR_R = 6'b000100,
        ST_TAKE_L = 6'b001000,
        ST_TAKE_R = 6'b010000,
        ST_SHIFT = 6'b100000
    } fetch_state_t;

endpackage

// File: design/osd_pixel_divider.sv
module osd_pixel_divider
    import osd_pkg::*;
#(
    parameter int unsigned DIV = PIX_DIV_DEF
)(
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;
    logic tick_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
            tick_q <= (cnt_q == LAST);
        end
    end

    assign tick = tick_q;

endmodule

// File: design/osd_cell_fetch.sv
module osd_cell_fetch
    import osd_pkg::*;
#(
    parameter int unsigned NUM_COLS = 24,
    parameter int unsigned COL_W = 5
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pix_en,
    input wire logic line_start,
    input wire logic [5:0] row_line,
    input wire logic [1:0] size,
    input wire logic char_en,
    input wire logic smooth_en,
    input wire logic [11:0] video_refresh_ram_word,
    output logic [COL_W-1:0] col,
    output logic [14:0] rom_addr,
    input wire logic [6:0] rom_data,
    output logic busy,
    output logic pix_valid,
    output logic pix_fg,
    output logic pix_edge,
    output logic [2:0] pix_pal
);

    fetch_state_t state_q;
    logic [COL_W-1:0] col_q;
    logic [14:0] rom_addr_q;
    logic [8:0] code_q;
    logic [2:0] pal_q;
    logic [6:0] left_q;
    logic [13:0] sh_q;
    logic [3:0] cnt_q;
    logic half_q;
    logic prev_q;
    logic pix_valid_q;
    logic pix_fg_q;
    logic pix_edge_q;
    logic [2:0] pix_pal_q;

    wire wide = (size == SIZE_2X) || (size == SIZE_WIDE);
    wire tall = (size == SIZE_2X) || (size == SIZE_TALL);
    wire [4:0] row_raw = tall ? row_line[5:1] : row_line[4:0];
    wire [4:0] pat_row = (row_raw > LAST_ROW) ? LAST_ROW : row_raw;
    wire [8:0] cell_code = {video_refresh_ram_word[WORD_MSB], video_refresh_ram_word[7:0]};
    wire cur = sh_q[13];
    wire next = (cnt_q == LAST_PIX) ? 1'b0 : sh_q[12];
    wire advance = pix_en && (!wide || half_q);
    wire smooth_on = smooth_en && wide;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_IDLE;
            col_q <= '0;
            rom_addr_q <= 15'h0000;
            code_q <= 9'h000;
            pal_q <= 3'h0;
            left_q <= 7'h00;
            sh_q <= 14'h0000;
            cnt_q <= 4'h0;
            half_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (line_start)
                    begin
                        col_q <= '0;
                        state_q <= ST_ADDR_L;
                    end
                end
                ST_ADDR_L:
                begin
                    rom_addr_q <= {cell_code, pat_row, 1'b0};
                    code_q <= cell_code;
                    pal_q <= video_refresh_ram_word[10:8];
                    state_q <= ST_ADDR_R;
                end
                ST_ADDR_R:
                begin
                    rom_addr_q <= {code_q, pat_row, 1'b1};
                    state_q <= ST_TAKE_L;
                end
                ST_TAKE_L:
                begin
                    left_q <= rom_data;
                    state_q <= ST_TAKE_R;
                end
                ST_TAKE_R:
                begin
                    sh_q <= {left_q, rom_data};
                    cnt_q <= 4'h0;
                    half_q <= 1'b0;
                    prev_q <= 1'b0;
                    state_q <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    if (pix_en && wide)
                    begin
                        half_q <= !half_q;
                    end
                    if (advance)
                    begin
                        sh_q <= {sh_q[12:0], 1'b0};
                        prev_q <= cur;
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == LAST_PIX)
                        begin
                            if (col_q == COL_W'(NUM_COLS - 1))
                            begin
                                state_q <= ST_IDLE;
                            end
                            else
                            begin
                                col_q <= col_q + COL_W'(1);
                                state_q <= ST_ADDR_L;
                            end
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // fetch gaps show as transparent pixels; a divider of 4 or more hides little
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pix_valid_q <= 1'b0;
            pix_fg_q <= 1'b0;
            pix_edge_q <= 1'b0;
            pix_pal_q <= 3'h0;
        end
        else if (pix_en)
        begin
            pix_valid_q <= (state_q == ST_SHIFT);
            pix_fg_q <= char_en && (cur || (smooth_on && half_q && next));
            pix_edge_q <= char_en && !cur && (prev_q || next);
            pix_pal_q <= pal_q;
        end
    end

    assign col = col_q;
    assign rom_addr = rom_addr_q;
    assign busy = (state_q != ST_IDLE);
    assign pix_valid = pix_valid_q;
    assign pix_fg = pix_fg_q;
    assign pix_edge = pix_edge_q;
    assign pix_pal = pix_pal_q;

endmodule

// File: dv/osd_rom_model.sv
module osd_rom_model
(
    input wire logic aclk,
    input wire logic [14:0] rom_addr,
    output logic [6:0] rom_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle pattern store: left half lit but its first pixel, right half dark
    always_ff @(posedge aclk)
    begin
        rom_data <= rom_addr[0] ? 7'h00 : 7'h3F;
    end
endmodule

// File: dv/osd_character_generator_tb.sv
module osd_character_generator_tb
    import osd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, line_start = 0, awready, wready, bvalid, arready, rvalid;
    logic osd_blank, video_mute, aw, w;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hF, row_index = 0;
    logic [5:0] row_line = 0;
    logic [1:0] bresp, rresp, rs;
    logic [14:0] rom_addr;
    logic [6:0] rom_data;
    logic [2:0] osd_rgb;
    int n_mismatch = 0, compares = 0, cyc = 0;
    logic [7:0] ta [3] = '{ADDR_DISPLAY_ATTRIBUTE_CTRL, ADDR_PAL_INDEX, ADDR_INT_STATUS};
    logic [31:0] td [3] = '{32'h0000_00A5, 32'h0000_000B, 32'h0000_00FF};
    logic [31:0] te [3] = '{32'h0000_00A5, 32'h0000_00FB, 32'h0000_00F0};
    osd_character_generator osd_character_generator_inst (.*);
    osd_rom_model osd_rom_model_inst (.aclk(aclk), .rom_addr(rom_addr), .rom_data(rom_data));
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    task automatic test_done;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        aw = 0;
        w = 0;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                aw = 1;
                awvalid <= 0;
            end
            if (wvalid && wready)
            begin
                w = 1;
                wvalid <= 0;
            end
        end
        bready <= 1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        rready <= 1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 0;
    endtask
    task automatic wait_rgb(input logic [2:0] e);
        for (int i = 0; i < 200 && osd_rgb !== e; i++) @(posedge aclk);
        chk(osd_rgb, e);
    endtask
    task automatic line_count(input logic [2:0] e, input int n);
        int k;
        k = 0;
        line_start <= 1;
        @(posedge aclk);
        line_start <= 0;
        repeat (3200)
        begin
            @(posedge aclk);
            if (osd_rgb === e)
                k++;
        end
        chk(k, n);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(ADDR_DISPLAY_ATTRIBUTE_CTRL);
        chk(rd, 32'h0000_0000);
        rdr(ADDR_PAL_INDEX);
        chk(rd, 32'h0000_00F0);
        for (int i = 0; i < 3; i++)
        begin
            wr(ta[i], td[i]);
            rdr(ta[i]);
            chk(rd, te[i]);
        end
        wr(8'h3C, 32'h0000_0001);
        chk(rs, RESP_SLVERR);
        rdr(8'h3C);
        chk(rd, 32'h0000_0000);
        chk(rs, RESP_SLVERR);
        // merged ram word: msb 1, palette 5, byte a7 at cell 5
        wr(ADDR_PAL_INDEX, 32'h0000_000D);
        wr(ADDR_VIDEO_REFRESH_RAM, 32'h0000_05A7);
        rdr(ADDR_VIDEO_REFRESH_RAM);
        chk(rd, 32'h0DA7_0005);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0041);
        wait_rgb(3'b001);
        chk(video_mute, 1'b1);
        chk(osd_blank, 1'b1);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0049);
        wait_rgb(3'b110);
        // palette 0 takes row colours, fg red, bg blue; cell 5 uses slot 4, fg red, bg black
        wr(ADDR_ROW_ATTRIBUTE_WORD, 32'h0000_0021);
        wr(ADDR_PALETTE + 8'h10, 32'h0000_0020);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0080);
        @(posedge aclk);
        chk(video_mute, 1'b0);
        // six lit pixels a cell, 24 cells, four clocks a pixel; doubled width twice that, smoothed 2X four clocks a cell more
        line_count(3'b100, 576);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_00A0);
        line_count(3'b111, 192);
        wr(ADDR_MODE, 32'h0000_0004);
        line_count(3'b111, 0);
        wr(ADDR_MODE, 32'h0000_0001);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0080);
        line_count(3'b100, 1248);
        wr(ADDR_MODE, 32'h0000_0002);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0090);
        line_count(3'b100, 1152);
        wr(ADDR_MODE, 32'h0000_0003);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0080);
        line_count(3'b100, 576);
        wr(ADDR_DISPLAY_ATTRIBUTE_CTRL, 32'h0000_0000);
        line_count(3'b100, 0);
        test_done();
    end
endmodule
